/* charger_status_control_registers.sv */
// Serial slave front end for the charger status and control register bank.
`timescale 1ns/1ps
// Behaviour
// - Writing one to offset 0 bit 7 kicks the safety timer; the bit self-clears.
// - Reading offset 0 bit 7 returns the present on-the-go pin level.
// - Offset 0 bit 6 is read/write indicator-pin enable, default one.
// - Offset 0 bits 5:4 report ready, charging, done or fault.
// - Offset 0 bit 3 reads one only while in boost mode.
// - In charge mode offset 0 bits 2:0 carry the eight charge fault codes.
// - In boost mode bits 2:0 carry boost fault codes; code seven is unused.
// - After reset offset 0 reads bit 6 set and bit 3 clear.
// - Offset 1 bits 7:6 select 100, 500, 800 mA or no input limit.
// - Offset 1 bits 5:4 add 200 and 100 mV to a 3.4 V threshold.
// - Offset 1 bit 3 enables low-current termination, default zero.
// - Offset 1 bit 2 disables the charger when one, default zero.
// - Offset 1 bit 1 selects high-impedance mode when one, default zero.
// - Offset 1 bit 0 selects boost when one, charger when zero.
// - Offset 1 resets to 0x30.
// - Answer only the fixed seven-bit address; the master uses seven-bit addressing.
// - Reading an unimplemented offset returns 0xFF.
// - A write lands on the falling edge ending its data acknowledge.
module charger_status_control_registers #(
   parameter logic [6:0] DEV_ADDR = charger_regs_pkg::SLAVE_ADDR
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic i_on_the_go_pin,
   input wire charger_regs_pkg::charger_status_t i_status,
   output charger_regs_pkg::charger_control_t o_control,
   output logic o_stat_pin_enable,
   output logic o_timer_kick
);
   import charger_regs_pkg::*;

   // Reserved serial addresses cannot be served by this slave.
   if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
      $error("slave address lies in a reserved range");
   end

   // Byte-level position within a transfer.
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_REG,
      ST_ACK_REG,
      ST_WDATA,
      ST_ACK_WDATA,
      ST_RDATA,
      ST_ACK_RDATA
   } bus_state_t;

   bus_state_t state_q;
   bus_state_t state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic oe_q;
   logic oe_d;
   logic rw_q;
   logic rw_d;
   logic nack_q;
   logic nack_d;
   logic wr_en;

   logic [2:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic otg_s;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic byte_done;
   logic addr_match;
   logic [7:0] rd_data;

   // The bus clock is sampled like any pin: the slave runs wholly on i_clk,
   // trading a bus rate ceiling for a single clock domain.
   pin_sync #(
      .WIDTH(3),
      .IDLE(3'h7)
   ) u_pin_sync (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_async({i_on_the_go_pin, i_sda, i_scl}),
      .o_sync(pins_s)
   );

   // Named views of the synchronised pins.
   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign otg_s = pins_s[2];

   // Previous levels for edge and condition detection; idle bus is high.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // Clock edges and start/stop conditions. A data change while the clock
   // is high is always a condition, never data, so the master must keep the
   // data line still during the high phase.
   assign scl_rise = scl_s && !scl_prev_q;
   assign scl_fall = !scl_s && scl_prev_q;
   assign start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;

   // Byte completion and address comparison.
   assign byte_done = (cnt_q == BYTE_BITS);
   assign addr_match = (shift_q[7:1] == DEV_ADDR);

   // Transfer sequencing. Data is sampled on rising clock edges; the slave
   // changes its own drive only on falling edges so the line is stable while
   // the clock is high.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      oe_d = oe_q;
      rw_d = rw_q;
      nack_d = nack_q;
      wr_en = 1'b0;
      if (stop_cond) begin
         // A stop always releases the bus, whatever the slave was doing.
         state_d = ST_IDLE;
         oe_d = 1'b0;
      end else if (start_cond) begin
         // Start and repeated start both restart address reception.
         state_d = ST_ADDR;
         cnt_d = '0;
         oe_d = 1'b0;
      end else if (scl_rise) begin
         case (state_q)
            ST_ADDR, ST_REG, ST_WDATA: begin
               shift_d = {shift_q[6:0], sda_s};
               cnt_d = cnt_q + 4'h1;
            end
            ST_RDATA: begin
               cnt_d = cnt_q + 4'h1;
            end
            ST_ACK_RDATA: begin
               nack_d = sda_s;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_q)
            ST_ADDR: begin
               if (byte_done) begin
                  // Foreign addresses, including a high-speed master code,
                  // get no acknowledge and are ignored to the next condition.
                  if (addr_match) begin
                     state_d = ST_ACK_ADDR;
                     oe_d = 1'b1;
                     rw_d = shift_q[0];
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_ACK_ADDR: begin
               cnt_d = '0;
               if (rw_q) begin
                  state_d = ST_RDATA;
                  shift_d = rd_data;
                  oe_d = !rd_data[7];
               end else begin
                  state_d = ST_REG;
                  oe_d = 1'b0;
               end
            end
            ST_REG: begin
               if (byte_done) begin
                  ptr_d = shift_q;
                  state_d = ST_ACK_REG;
                  oe_d = 1'b1;
               end
            end
            ST_ACK_REG: begin
               state_d = ST_WDATA;
               cnt_d = '0;
               oe_d = 1'b0;
            end
            ST_WDATA: begin
               if (byte_done) begin
                  state_d = ST_ACK_WDATA;
                  oe_d = 1'b1;
               end
            end
            ST_ACK_WDATA: begin
               // The update lands as the acknowledge ends; the next byte is a
               // fresh register offset, so back-to-back updates need no start.
               wr_en = 1'b1;
               state_d = ST_REG;
               cnt_d = '0;
               oe_d = 1'b0;
            end
            ST_RDATA: begin
               if (byte_done) begin
                  state_d = ST_ACK_RDATA;
                  oe_d = 1'b0;
               end else begin
                  shift_d = {shift_q[6:0], 1'b0};
                  oe_d = !shift_q[6];
               end
            end
            ST_ACK_RDATA: begin
               // The pointer does not advance: repeated reads return the same
               // offset with its value freshly sampled.
               if (nack_q) begin
                  state_d = ST_IDLE;
               end else begin
                  state_d = ST_RDATA;
                  cnt_d = '0;
                  shift_d = rd_data;
                  oe_d = !rd_data[7];
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // Sequencer state.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         shift_q <= '0;
         ptr_q <= REG_STATUS_ADDR;
         oe_q <= 1'b0;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         oe_q <= oe_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
      end
   end

   // Register storage and read selection; the write data is the byte just
   // received, which stays in the shift register through the acknowledge.
   charger_reg_bank u_reg_bank (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_wr_en(wr_en),
      .i_addr(ptr_q),
      .i_wr_data(shift_q),
      .i_otg_level(otg_s),
      .i_status(i_status),
      .o_rd_data(rd_data),
      .o_control(o_control),
      .o_stat_pin_enable(o_stat_pin_enable),
      .o_timer_kick(o_timer_kick)
   );

   // Open-drain data line: the slave only ever pulls low.
   assign o_sda_out = 1'b0;
   assign o_sda_oe = oe_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // An address byte has just completed on a falling clock edge.
   sequence addr_byte_end;
      state_q == ST_ADDR && byte_done && scl_fall && !stop_cond && !start_cond;
   endsequence

   // The data acknowledge slot is closing.
   sequence wdata_ack_end;
      state_q == ST_ACK_WDATA && scl_fall && !stop_cond && !start_cond;
   endsequence

   AST_ACK_OWN_ADDR: assert property (
      addr_byte_end |=> (o_sda_oe == (shift_q[7:1] == DEV_ADDR)))
      else $error("address acknowledge does not match the slave address");
   AST_NO_FOREIGN_ACK: assert property (
      (addr_byte_end and !addr_match) |=> state_q == ST_IDLE ##1 !o_sda_oe)
      else $error("foreign address was not ignored");
   AST_WRITE_AT_ACK_END: assert property (
      wr_en |-> $past(o_sda_oe) && state_q == ST_ACK_WDATA)
      else $error("write not taken at the end of the data acknowledge");
   AST_WRITE_RELEASES: assert property (
      wdata_ack_end |-> wr_en ##1 (!o_sda_oe && state_q == ST_REG && cnt_q == 4'h0))
      else $error("data acknowledge did not release into a new offset byte");
   AST_STOP_RELEASES: assert property (
      stop_cond |=> !o_sda_oe && state_q == ST_IDLE)
      else $error("stop did not release the bus");
endmodule // charger_status_control_registers

/* charger_regs_pkg.sv */
// Shared constants and carrier types for the charger status and control register bank.
package charger_regs_pkg;

   // Register offsets as seen in the register address byte.
   localparam logic [7:0] REG_STATUS_ADDR = 8'h00;
   localparam logic [7:0] REG_CONTROL_ADDR = 8'h01;

   // Value returned for any register offset that this bank does not hold.
   localparam logic [7:0] UNMAPPED_READ = 8'hFF;

   // Fixed seven-bit slave address.
   localparam logic [6:0] SLAVE_ADDR = 7'h6A;

   // Field positions and reset values of the status/control register.
   localparam int TIMER_KICK_BIT = 7;
   localparam int STAT_EN_BIT = 6;
   localparam logic STAT_EN_RESET = 1'b1;

   // Reset value of the operating control register.
   localparam logic [7:0] CONTROL_RESET = 8'h30;

   // Fault codes with a special meaning in this bank.
   localparam logic [2:0] FAULT_NORMAL = 3'h0;
   localparam logic [2:0] FAULT_BOOST_UNUSED = 3'h7;

   // Charge state codes.
   localparam logic [1:0] CHG_READY = 2'h0;
   localparam logic [1:0] CHG_IN_PROGRESS = 2'h1;
   localparam logic [1:0] CHG_DONE = 2'h2;
   localparam logic [1:0] CHG_FAULT = 2'h3;

   // Input current limit codes.
   localparam logic [1:0] ILIM_100MA = 2'h0;
   localparam logic [1:0] ILIM_500MA = 2'h1;
   localparam logic [1:0] ILIM_800MA = 2'h2;
   localparam logic [1:0] ILIM_NONE = 2'h3;

   // Weak battery threshold: base and step sizes in millivolts.
   localparam int WEAK_BATT_BASE_MV = 3400;
   localparam int WEAK_BATT_LSB_MV = 100;

   // Bits in one serial byte, counted before the acknowledge slot.
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Live charger condition reported by the analog side, same clock domain.
   typedef struct packed {
      logic [1:0] charge_state;
      logic boost;
      logic [2:0] fault;
   } charger_status_t;

   // Operating control, laid out exactly as the register bits 7 down to 0.
   typedef struct packed {
      logic [1:0] input_limit;
      logic weak_battery_thresh_msb;
      logic weak_battery_thresh_lsb;
      logic termination_enable;
      logic charger_disable;
      logic high_impedance_select;
      logic operating_mode_select;
   } charger_control_t;

endpackage

/* pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] IDLE = '1
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs at least one bit");
   end

   // The first stage is read only by the second stage of the same bit.
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      logic meta_q;
      always_ff @(posedge i_clk or negedge i_resetn) begin
         if (!i_resetn) begin
            meta_q <= IDLE[b];
            o_sync[b] <= IDLE[b];
         end else begin
            meta_q <= i_async[b];
            o_sync[b] <= meta_q;
         end
      end
   end
endmodule // pin_sync

/* charger_reg_bank.sv */
// Storage, read selection and side effects of the two charger registers.
`timescale 1ns/1ps
module charger_reg_bank (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_wr_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_otg_level,
   input wire charger_regs_pkg::charger_status_t i_status,
   output logic [7:0] o_rd_data,
   output charger_regs_pkg::charger_control_t o_control,
   output logic o_stat_pin_enable,
   output logic o_timer_kick
);
   import charger_regs_pkg::*;

   charger_status_t status_q;
   logic [2:0] fault_shown;
   logic [7:0] status_word;
   logic hit_status;
   logic hit_control;

   // Address decode for the two implemented offsets.
   assign hit_status = (i_addr == REG_STATUS_ADDR);
   assign hit_control = (i_addr == REG_CONTROL_ADDR);

   // The unused boost-mode code reads as normal rather than a false fault.
   assign fault_shown = (status_q.boost && status_q.fault == FAULT_BOOST_UNUSED) ?
      FAULT_NORMAL : status_q.fault;

   // Bit 7 reads the pin, never the kick request.
   assign status_word = {i_otg_level, o_stat_pin_enable, status_q.charge_state,
      status_q.boost, fault_shown};

   // Read selection; any other offset answers all ones.
   assign o_rd_data = hit_status ? status_word :
      (hit_control ? o_control : UNMAPPED_READ);

   // Status snapshot starts clear, so boost reads zero until the charger reports it.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_q <= '0;
      end else begin
         status_q <= i_status;
      end
   end

   // Only the indicator enable is stored at offset 0; read-only bits drop writes.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_stat_pin_enable <= STAT_EN_RESET;
         o_control <= CONTROL_RESET;
         o_timer_kick <= 1'b0;
      end else begin
         o_timer_kick <= i_wr_en && hit_status && i_wr_data[TIMER_KICK_BIT];
         if (i_wr_en && hit_status) begin
            o_stat_pin_enable <= i_wr_data[STAT_EN_BIT];
         end
         if (i_wr_en && hit_control) begin
            o_control <= i_wr_data;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   AST_TIMER_KICK_PULSE: assert property (
      (i_wr_en && hit_status && i_wr_data[TIMER_KICK_BIT]) |=> o_timer_kick ##1 !o_timer_kick)
      else $error("timer kick is not a single cycle pulse");
   AST_OTG_READBACK: assert property (
      hit_status |-> o_rd_data[TIMER_KICK_BIT] == i_otg_level)
      else $error("status bit 7 does not follow the pin");
   AST_STAT_EN_WRITE: assert property (
      (i_wr_en && hit_status) |=> o_stat_pin_enable == $past(i_wr_data[STAT_EN_BIT]))
      else $error("indicator enable not written");
   AST_STATE_READBACK: assert property (
      (hit_status && $past(i_resetn)) |->
      o_rd_data[5:3] == {$past(i_status.charge_state), $past(i_status.boost)})
      else $error("charge state or boost flag misreported");
   AST_BOOST_NO_CODE7: assert property (
      (hit_status && o_rd_data[3]) |-> o_rd_data[2:0] != FAULT_BOOST_UNUSED)
      else $error("unused boost fault code reported");
   AST_CONTROL_WRITE: assert property (
      (i_wr_en && hit_control) |=> o_control == $past(i_wr_data))
      else $error("control register not written");
   AST_UNMAPPED_FF: assert property (
      (!hit_status && !hit_control) |-> o_rd_data == UNMAPPED_READ)
      else $error("unmapped offset did not read all ones");
endmodule // charger_reg_bank

/* i2c_host_model.sv */
// Behavioural serial bus master that drives the register link of the charger bank.
`timescale 1ns/1ps
module i2c_host_model (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe
);

   // The bus idles with both lines released to the pull-ups.
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   // Ten system clocks per clock phase, well above the slave's sampling minimum.
   task automatic half();
      repeat (10) @(posedge i_clk);
      #1;
   endtask

   // Data moves only a few clocks after the clock fell, so it is never mistaken for a stop.
   task automatic clk_bit(input logic b, output logic s);
      repeat (3) @(posedge i_clk);
      #1;
      o_sda_oe = ~b;
      half();
      o_scl = 1'b1;
      half();
      s = i_sda;
      o_scl = 1'b0;
   endtask

   // Start and repeated start share one sequence.
   task automatic start();
      repeat (3) @(posedge i_clk);
      #1;
      o_sda_oe = 1'b0;
      half();
      o_scl = 1'b1;
      half();
      o_sda_oe = 1'b1;
      half();
      o_scl = 1'b0;
   endtask

   task automatic stop();
      repeat (3) @(posedge i_clk);
      #1;
      o_sda_oe = 1'b1;
      half();
      o_scl = 1'b1;
      half();
      o_sda_oe = 1'b0;
      half();
   endtask

   // Eight bits MSB first, then the acknowledge slot; ack_n low means acknowledged.
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack_n);
      for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
      clk_bit(last, ack_n);
   endtask

   // One register update: address, offset, data.
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d,
                            output logic ok);
      logic [7:0] q;
      logic a0 = 1'b1;
      logic a1 = 1'b1;
      logic a2 = 1'b1;
      start();
      xfer({dev, 1'b0}, 1'b1, q, a0);
      if (!a0) begin
         xfer(off, 1'b1, q, a1);
         xfer(d, 1'b1, q, a2);
      end
      stop();
      ok = ~(a0 | a1 | a2);
   endtask

   // Pointer set, repeated start, one byte read and closed with a not-acknowledge.
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] off, output logic [7:0] d,
                           output logic ok);
      logic [7:0] q;
      logic a0, a1, a2, a3;
      start();
      xfer({dev, 1'b0}, 1'b1, q, a0);
      xfer(off, 1'b1, q, a1);
      start();
      xfer({dev, 1'b1}, 1'b1, q, a2);
      xfer(8'hFF, 1'b1, d, a3);
      stop();
      ok = ~(a0 | a1 | a2);
   endtask

endmodule // i2c_host_model

/* charger_status_control_registers_tb.sv */
// Self-checking bench for the charger status and control register bank.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module charger_status_control_registers_tb;
   import charger_regs_pkg::*;

   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_on_the_go_pin = 1'b1;
   logic scl, host_oe, o_sda_out, o_sda_oe, o_stat_pin_enable, o_timer_kick, ok;
   charger_status_t status_in = '0;
   charger_control_t o_control;
   logic [7:0] d;
   logic [15:0] lfsr = 16'h9CE1;
   int error_cnt = 0;
   int checks = 0;
   int kick_cnt = 0;
   int kick0;

   // Open-drain data line: the pull-up wins unless someone pulls low.
   wire sda = (o_sda_oe ? o_sda_out : 1'b1) & ~host_oe;

   always #2.5 i_clk = ~i_clk;

   // Counting high cycles also proves the kick is a single-cycle pulse; the
   // falling edge samples the pulse away from the edge that launches it.
   always @(negedge i_clk) if (o_timer_kick === 1'b1) kick_cnt++;

   charger_status_control_registers u_charger_status_control_registers (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda),
      .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_on_the_go_pin(i_on_the_go_pin),
      .i_status(status_in), .o_control(o_control), .o_stat_pin_enable(o_stat_pin_enable),
      .o_timer_kick(o_timer_kick)
   );

   i2c_host_model u_i2c_host_model (
      .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe)
   );

   function automatic logic [15:0] next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected status byte; boost mode hides the unused fault code.
   function automatic logic [7:0] exp_status(input logic on_the_go_pin, input logic en,
                                             input charger_status_t s);
      logic [2:0] f;
      f = (s.boost && s.fault == FAULT_BOOST_UNUSED) ? FAULT_NORMAL : s.fault;
      return {on_the_go_pin, en, s.charge_state, s.boost, f};
   endfunction

   task automatic wr(input logic [7:0] off, input logic [7:0] v);
      u_i2c_host_model.write_reg(SLAVE_ADDR, off, v, ok);
      `CHECK("write ack", 1'b1, ok)
   endtask

   task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp, input string nm);
      logic [7:0] v;
      u_i2c_host_model.read_reg(SLAVE_ADDR, off, v, ok);
      `CHECK("read ack", 1'b1, ok)
      `CHECK(nm, exp, v)
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Inputs change one nanosecond after the rising edge, never on it.
   initial begin
      repeat (4) @(posedge i_clk);
      #1 i_resetn = 1'b1;
      repeat (6) @(posedge i_clk);
      `CHECK("control reset", CONTROL_RESET, o_control)
      `CHECK("stat enable reset", STAT_EN_RESET, o_stat_pin_enable)
      rd_chk(REG_CONTROL_ADDR, CONTROL_RESET, "reg1 reset");
      rd_chk(REG_STATUS_ADDR, 8'hC0, "reg0 reset");
      $display("test reset done");

      // Corner codes first, then random control bytes.
      for (int i = 0; i < 8; i++) begin
         lfsr = next(lfsr);
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : (i == 2) ? 8'h81 : (i == 3) ? 8'h4A : lfsr[7:0];
         wr(REG_CONTROL_ADDR, d);
         `CHECK("input limit", d[7:6], o_control.input_limit)
         `CHECK("control", d, o_control)
         rd_chk(REG_CONTROL_ADDR, d, "reg1 readback");
      end
      $display("test control done");

      // Every fault code in both modes, every charge state, random pin level.
      for (int i = 0; i < 16; i++) begin
         lfsr = next(lfsr);
         @(posedge i_clk);
         #1;
         status_in.fault = i[2:0];
         status_in.boost = i[3];
         status_in.charge_state = i[1:0] ^ lfsr[1:0];
         i_on_the_go_pin = lfsr[2];
         rd_chk(REG_STATUS_ADDR, exp_status(lfsr[2], 1'b1, status_in), "reg0");
      end
      $display("test status done");

      // Kick writes with the pin low: readback shows the pin, not the written one.
      @(posedge i_clk);
      #1 i_on_the_go_pin = 1'b0;
      status_in = '{charge_state: CHG_DONE, boost: 1'b1, fault: 3'h2};
      kick0 = kick_cnt;
      wr(REG_STATUS_ADDR, 8'hFF);
      `CHECK("kick count", kick0 + 1, kick_cnt)
      rd_chk(REG_STATUS_ADDR, exp_status(1'b0, 1'b1, status_in), "reg0 after kick");
      wr(REG_STATUS_ADDR, 8'h3F);
      `CHECK("stat enable", 1'b0, o_stat_pin_enable)
      `CHECK("kick count", kick0 + 1, kick_cnt)
      rd_chk(REG_STATUS_ADDR, exp_status(1'b0, 1'b0, status_in), "reg0 disabled");
      wr(REG_STATUS_ADDR, 8'hC0);
      `CHECK("stat enable", 1'b1, o_stat_pin_enable)
      `CHECK("kick count", kick0 + 2, kick_cnt)
      $display("test kick done");

      // Unimplemented offsets read all ones.
      rd_chk(8'h02, UNMAPPED_READ, "offset 02");
      rd_chk(8'h05, UNMAPPED_READ, "offset 05");
      rd_chk(8'hFF, UNMAPPED_READ, "offset FF");
      $display("test unmapped done");

      // A neighbouring address and the high-speed master code are both ignored.
      u_i2c_host_model.write_reg(SLAVE_ADDR ^ 7'h01, REG_CONTROL_ADDR, 8'h00, ok);
      `CHECK("foreign ack", 1'b0, ok)
      u_i2c_host_model.write_reg(7'h04, REG_CONTROL_ADDR, 8'h00, ok);
      `CHECK("master code ack", 1'b0, ok)
      `CHECK("control kept", d, o_control)
      $display("test address done");

      // A second reset in mid-run restores the defaults.
      @(posedge i_clk);
      #1 i_resetn = 1'b0;
      repeat (3) @(posedge i_clk);
      `CHECK("control reset", CONTROL_RESET, o_control)
      `CHECK("stat enable reset", STAT_EN_RESET, o_stat_pin_enable)
      #1 i_resetn = 1'b1;
      repeat (6) @(posedge i_clk);
      rd_chk(REG_CONTROL_ADDR, CONTROL_RESET, "reg1 after reset");
      $display("test second reset done");
      report_and_stop();
   end

   // About 45 transfers of under 1200 clocks each fit well inside this span.
   initial begin
      repeat (95000) @(posedge i_clk);
      error_cnt++;
      $display("watchdog expired");
      report_and_stop();
   end

endmodule // charger_status_control_registers_tb
